// ---- common/dcbe_pkg.sv ----
// Purpose: shared constants of the balanced line encoder
// Assumes: seven bit times per pixel cycle on every lane
// Notes:   control patterns are sent msb first
package dcbe_pkg;
   localparam int        DCBE_WORD_BITS  = 7;
   localparam int        DCBE_DATA_BITS  = 6;
   localparam int        DCBE_LANES      = 8;
   localparam int        DCBE_GROUP      = 4;
   localparam int        DCBE_PIX_BITS   = 48;
   localparam int        DCBE_CLK_LANES  = 2;
   localparam int        DCBE_BUS_BITS   = (DCBE_LANES + DCBE_CLK_LANES) * DCBE_WORD_BITS;
   localparam int        DCBE_RD_BITS    = 5;
   localparam int        DCBE_FLAG_POS   = 0;
   localparam int        DCBE_LAST_BIT   = 6;
   // running disparity limits and reset value
   localparam logic signed [4:0] DCBE_RD_MAX   = 5'sd7;
   localparam logic signed [4:0] DCBE_RD_MIN   = -5'sd6;
   localparam logic signed [4:0] DCBE_RD_RESET = 5'sd0;
   // control word patterns
   localparam logic [6:0] DCBE_CTL0_POS  = 7'h70;  // 1110000
   localparam logic [6:0] DCBE_CTL0_NEG  = 7'h78;  // 1111000
   localparam logic [6:0] DCBE_CTL1_POS  = 7'h60;  // 1100000
   localparam logic [6:0] DCBE_CTL1_NEG  = 7'h7c;  // 1111100
   localparam logic [6:0] DCBE_CLK_PLAIN = 7'h63;  // 1100011
   localparam logic [6:0] DCBE_WORD_IDLE = 7'h00;
   localparam logic [2:0] DCBE_BIT_RESET = 3'h0;
endpackage

// ---- core/dcbe_lane_balancer.sv ----
// Purpose: one data lane: disparity tracking, inversion and control words
// Assumes: all inputs on clock_in; word_out valid one cycle after inputs
// Notes:   flag occupies the lowest bit of the word
`timescale 1ns/10ps
module dcbe_lane_balancer
   import dcbe_pkg::*;
(
   // clock and reset
   input  wire logic                              clock_in,
   input  wire logic                              sys_rst_in,
   // lane inputs
   input  wire logic [dcbe_pkg::DCBE_DATA_BITS-1:0] data_in,
   input  wire logic                              ctrl_in,
   input  wire logic                              active_in,
   input  wire logic                              balance_in,
   input  wire logic                              lane_on_in,
   // lane outputs
   output logic      [dcbe_pkg::DCBE_WORD_BITS-1:0] word_out,
   output logic signed [dcbe_pkg::DCBE_RD_BITS-1:0] rd_out
);
   import dcbe_pkg::*;

   logic        [2:0]              ones;
   logic signed [DCBE_RD_BITS-1:0] disp;
   logic signed [DCBE_RD_BITS-1:0] delta;
   logic signed [DCBE_RD_BITS-1:0] next_rd;
   logic                           invert;
   logic        [6:0]              ctl_word;

   always_comb begin
      ones = 3'h0;
      for (int i = 0; i < DCBE_DATA_BITS; i++) begin
         ones = ones + {2'h0, data_in[i]};
      end
   end

   // ones minus zeros of the current word
   assign disp = $signed({1'b0, ones, 1'b0}) - 5'sd6;
   // positive rd inverts positive words, negative rd inverts the rest
   assign invert = (rd_out == 5'sd0) ? 1'b1 :
                   (rd_out > 5'sd0) ? (disp > 5'sd0) : (disp <= 5'sd0);
   assign delta = invert ? (5'sd1 - disp) : (disp - 5'sd1);

   always_comb begin
      next_rd = rd_out + delta;
      if (next_rd > DCBE_RD_MAX) begin
         next_rd = DCBE_RD_MAX;
      end else if (next_rd < DCBE_RD_MIN) begin
         next_rd = DCBE_RD_MIN;
      end
   end

   // control value selects pattern pair, rd picks one
   always_comb begin
      if (ctrl_in) begin
         ctl_word = (rd_out > 5'sd0) ? DCBE_CTL1_POS : DCBE_CTL1_NEG;
      end else begin
         ctl_word = (rd_out > 5'sd0) ? DCBE_CTL0_POS : DCBE_CTL0_NEG;
      end
   end

   // running disparity
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         rd_out <= DCBE_RD_RESET;
      end else if (balance_in && active_in && lane_on_in) begin
         rd_out <= next_rd;
      end
   end

   // lane word
   always_ff @(posedge clock_in) begin
      if (sys_rst_in || !lane_on_in) begin
         word_out <= DCBE_WORD_IDLE;
      end else if (!balance_in) begin
         word_out <= {data_in, ctrl_in};
      end else if (active_in) begin
         word_out <= {(invert ? ~data_in : data_in), invert};
      end else begin
         word_out <= ctl_word;
      end
   end

   AST_RD_RANGE: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      rd_out <= DCBE_RD_MAX && rd_out >= DCBE_RD_MIN)
      else $error("running disparity left its range");

   AST_ZERO_INVERTS: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      (balance_in && active_in && lane_on_in && rd_out == 5'sd0)
      |=> word_out[DCBE_FLAG_POS] == 1'b1)
      else $error("zero disparity word not inverted");

   AST_FLAG_MATCHES: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      (balance_in && active_in && lane_on_in)
      |=> word_out[DCBE_WORD_BITS-1:1] ==
          (word_out[DCBE_FLAG_POS] ? ~$past(data_in) : $past(data_in)))
      else $error("flag does not match sent polarity");

   AST_BLANK_FLAG: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      (balance_in && !active_in && lane_on_in) |=> word_out[DCBE_FLAG_POS] == 1'b0)
      else $error("flag set during blanking");

   AST_POS_RULE: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      (balance_in && active_in && lane_on_in && rd_out > 5'sd0)
      |=> word_out[DCBE_FLAG_POS] == ($past(disp) > 5'sd0))
      else $error("wrong polarity with positive disparity");

   AST_RD_STEP: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      (balance_in && active_in && lane_on_in && rd_out == 5'sd1 && disp == -5'sd2)
      |=> rd_out == -5'sd2)
      else $error("running disparity step wrong");
endmodule

// ---- core/dcbe_serializer.sv ----
// Purpose: link-clock side: takes word sets by handshake and shifts them out
// Assumes: word_in stable from req toggle until ack toggle
// Notes:   a set that arrives while one is pending replaces nothing; the source waits
`timescale 1ns/10ps
module dcbe_serializer
   import dcbe_pkg::*;
#(
   parameter int LANE_COUNT = dcbe_pkg::DCBE_LANES + dcbe_pkg::DCBE_CLK_LANES
)
(
   // link clock and reset
   input  wire logic                                  link_clk_in,
   input  wire logic                                  link_rst_in,
   // handshake from pixel domain
   input  wire logic [LANE_COUNT*dcbe_pkg::DCBE_WORD_BITS-1:0] word_in,
   input  wire logic                                  req_in,
   output logic                                       ack_out,
   // serial lanes
   output logic      [LANE_COUNT-1:0]                 serial_out
);
   import dcbe_pkg::*;

   logic [2:0]                               req_sync;
   logic                                     pending;
   logic [2:0]                               bit_cnt;
   logic [LANE_COUNT*DCBE_WORD_BITS-1:0]     shift_word;
   logic                                     word_end;

   assign word_end = (bit_cnt == 3'(DCBE_LAST_BIT));

   always_ff @(posedge link_clk_in) begin
      if (link_rst_in) begin
         req_sync <= 3'h0;
      end else begin
         req_sync <= {req_sync[1:0], req_in};
      end
   end

   always_ff @(posedge link_clk_in) begin
      if (link_rst_in) begin
         pending <= 1'b0;
      end else if (req_sync[2] != req_sync[1]) begin
         pending <= 1'b1;
      end else if (word_end) begin
         pending <= 1'b0;
      end
   end

   always_ff @(posedge link_clk_in) begin
      if (link_rst_in) begin
         bit_cnt <= DCBE_BIT_RESET;
      end else if (word_end) begin
         bit_cnt <= DCBE_BIT_RESET;
      end else begin
         bit_cnt <= bit_cnt + 3'h1;
      end
   end

   always_ff @(posedge link_clk_in) begin
      if (link_rst_in) begin
         shift_word <= '0;
         ack_out    <= 1'b0;
      end else if (word_end && pending) begin
         shift_word <= word_in;
         ack_out    <= ~ack_out;
      end else begin
         for (int l = 0; l < LANE_COUNT; l++) begin
            shift_word[l*DCBE_WORD_BITS +: DCBE_WORD_BITS] <=
               {shift_word[l*DCBE_WORD_BITS +: DCBE_WORD_BITS-1],
                shift_word[l*DCBE_WORD_BITS + DCBE_WORD_BITS-1]};
         end
      end
   end

   always_comb begin
      for (int l = 0; l < LANE_COUNT; l++) begin
         serial_out[l] = shift_word[l*DCBE_WORD_BITS + DCBE_WORD_BITS-1];
      end
   end

   sequence s_word_taken;
      word_end && pending;
   endsequence

   AST_ACK_ON_LOAD: assert property (@(posedge link_clk_in) disable iff (link_rst_in)
      s_word_taken |=> (ack_out != $past(ack_out)) ##1 (bit_cnt == 3'h1))
      else $error("word load without acknowledge");
endmodule

// ---- core/dcbe_encoder.sv ----
// Purpose: balanced line encoder of the display serial transmitter
// Assumes: pixel port synchronous to clock_in; straps are static pins
// Notes:   handshake passes at most one word set every three pixel cycles, whatever the link rate
`timescale 1ns/10ps
module dcbe_encoder
   import dcbe_pkg::*;
(
   // clocks and reset
   input  wire logic                                clock_in,
   input  wire logic                                sys_rst_in,
   input  wire logic                                link_clk_in,
   // pixel port
   input  wire logic [dcbe_pkg::DCBE_PIX_BITS-1:0]  pixel_data_in,
   input  wire logic                                hsync_in,
   input  wire logic                                vsync_in,
   input  wire logic                                display_active_in,
   // straps
   input  wire logic                                primary_edge_select_in,
   input  wire logic                                active_polarity_select_in,
   input  wire logic                                balance_select_in,
   input  wire logic                                pixel_width_select_in,
   // serial lanes
   output logic      [dcbe_pkg::DCBE_LANES-1:0]     data_lane_out,
   output logic      [dcbe_pkg::DCBE_LANES-1:0]     data_lane_oe_out,
   output logic                                     serial_clock_lane_one_out,
   output logic                                     serial_clock_lane_two_out,
   output logic                                     serial_clock_lane_two_oe_out,
   // status
   output logic signed [dcbe_pkg::DCBE_RD_BITS-1:0] running_disparity_out
);
   import dcbe_pkg::*;

   localparam int GROUP_BITS = DCBE_GROUP * DCBE_DATA_BITS;

   logic [3:0]                       strap_meta;
   logic [3:0]                       strap;
   logic                             edge_fall;
   logic                             pol_high;
   logic                             bal_on;
   logic                             dual_on;
   logic [DCBE_PIX_BITS-1:0]         fall_pix;
   logic [2:0]                       fall_ctl;
   logic [DCBE_PIX_BITS-1:0]         pix;
   logic [2:0]                       ctl;
   logic                             active;
   logic [DCBE_LANES*DCBE_WORD_BITS-1:0] lane_words;
   logic signed [DCBE_RD_BITS-1:0]   lane_rd [DCBE_LANES];
   logic [DCBE_WORD_BITS-1:0]        clk_word;
   logic [DCBE_BUS_BITS-1:0]         xfer_word;
   logic                             req;
   logic                             ack;
   logic [1:0]                       ack_sync;
   logic [1:0]                       link_rst_sync;
   logic [DCBE_LANES+DCBE_CLK_LANES-1:0] serial;

   assign edge_fall = strap[0];
   assign pol_high  = strap[1];
   assign bal_on    = strap[2];
   assign dual_on   = strap[3];

   // strap pins pass two flops
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         strap_meta <= 4'h0;
         strap      <= 4'h0;
      end else begin
         strap_meta <= {pixel_width_select_in, balance_select_in,
                        active_polarity_select_in, primary_edge_select_in};
         strap      <= strap_meta;
      end
   end

   // falling-edge capture of the pixel port
   always_ff @(negedge clock_in) begin
      if (sys_rst_in) begin
         fall_pix <= '0;
         fall_ctl <= 3'h0;
      end else begin
         fall_pix <= pixel_data_in;
         fall_ctl <= {display_active_in, vsync_in, hsync_in};
      end
   end

   // primary edge selection
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         pix <= '0;
         ctl <= 3'h0;
      end else if (edge_fall) begin
         pix <= fall_pix;
         ctl <= fall_ctl;
      end else begin
         pix <= pixel_data_in;
         ctl <= {display_active_in, vsync_in, hsync_in};
      end
   end

   // active level follows polarity; depends on enable being always present
   assign active = pol_high ? ctl[2] : ~ctl[2];

   genvar g;
   generate
      for (g = 0; g < DCBE_LANES; g++) begin : gen_lane
         logic lane_ctrl;
         logic lane_on;
         // unbalanced lanes carry sync and enable in the spare bit
         assign lane_ctrl = (g == 0) ? ctl[0] :
                            (g == 1) ? ctl[1] :
                            (g == 2 && !bal_on) ? ctl[2] : 1'b0;
         assign lane_on   = (g < DCBE_GROUP) || dual_on;
         dcbe_lane_balancer u_lane (
            .clock_in   (clock_in),
            .sys_rst_in (sys_rst_in),
            .data_in    (pix[(g/DCBE_GROUP)*GROUP_BITS + (g%DCBE_GROUP)*DCBE_DATA_BITS +:
                             DCBE_DATA_BITS]),
            .ctrl_in    (lane_ctrl),
            .active_in  (active),
            .balance_in (bal_on),
            .lane_on_in (lane_on),
            .word_out   (lane_words[g*DCBE_WORD_BITS +: DCBE_WORD_BITS]),
            .rd_out     (lane_rd[g])
         );
      end
   endgenerate

   assign running_disparity_out = lane_rd[0];

   // clock lane word; control value is the inverse of the active state for either polarity
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         clk_word <= DCBE_CLK_PLAIN;
      end else if (!bal_on) begin
         clk_word <= DCBE_CLK_PLAIN;
      end else if (active) begin
         clk_word <= (lane_rd[0] > 5'sd0) ? DCBE_CTL0_POS : DCBE_CTL0_NEG;
      end else begin
         clk_word <= (lane_rd[0] > 5'sd0) ? DCBE_CTL1_POS : DCBE_CTL1_NEG;
      end
   end

   // handshake toward the link domain
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         ack_sync <= 2'h0;
      end else begin
         ack_sync <= {ack_sync[0], ack};
      end
   end

   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         xfer_word <= '0;
         req       <= 1'b0;
      end else if (ack_sync[1] == req) begin
         // both clock lanes from one word in dual mode
         xfer_word <= {clk_word, (dual_on ? clk_word : DCBE_WORD_IDLE),
                       lane_words};
         req       <= ~req;
      end
   end

   // reset carried into the link domain
   always_ff @(posedge link_clk_in) begin
      link_rst_sync <= {link_rst_sync[0], sys_rst_in};
   end

   dcbe_serializer #(
      .LANE_COUNT (DCBE_LANES + DCBE_CLK_LANES)
   ) u_ser (
      .link_clk_in (link_clk_in),
      .link_rst_in (link_rst_sync[1]),
      .word_in     (xfer_word),
      .req_in      (req),
      .ack_out     (ack),
      .serial_out  (serial)
   );

   assign data_lane_out                = serial[DCBE_LANES-1:0];
   assign serial_clock_lane_two_out    = serial[DCBE_LANES];
   assign serial_clock_lane_one_out    = serial[DCBE_LANES+1];
   assign data_lane_oe_out             = {{DCBE_GROUP{dual_on}}, {DCBE_GROUP{1'b1}}};
   assign serial_clock_lane_two_oe_out = dual_on;

   AST_CLK_LANES_SAME: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      ($past(dual_on) && $changed(req))
      |-> xfer_word[DCBE_BUS_BITS-1 -: 7] == xfer_word[DCBE_BUS_BITS-8 -: 7])
      else $error("clock lanes differ in dual mode");

   AST_SINGLE_OFF: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      (!dual_on && !$past(dual_on)) |->
         lane_words[DCBE_LANES*DCBE_WORD_BITS-1 : DCBE_GROUP*DCBE_WORD_BITS] == '0
         && serial_clock_lane_two_oe_out == 1'b0)
      else $error("second lane group active in single mode");

   AST_CLK_ACTIVE: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      (bal_on && active) |=> (clk_word == DCBE_CTL0_POS || clk_word == DCBE_CTL0_NEG))
      else $error("clock lane pattern wrong during active display");

   AST_PLAIN_CLK: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      !bal_on |=> clk_word == DCBE_CLK_PLAIN)
      else $error("clock lane not plain in unbalanced mode");
endmodule

// ---- sim/dcbe_panel_rx.sv ----
// Purpose: panel receiver model, deframes serial lanes into 7-bit words
// Assumes: lane bits change on link clock rise, msb of each word first
// Notes:   locks on a legal clock-lane word, relocks once one is lost
`timescale 1ns/10ps
module dcbe_panel_rx (
   // link side
   input  wire logic            link_clk_in,
   input  wire logic            balance_select_in,
   input  wire logic [7:0]      data_lane_in,
   input  wire logic            clk_one_in,
   input  wire logic            clk_two_in,
   // deframed words
   output logic      [7:0][6:0] data_word_out,
   output logic      [6:0]      clk_one_word_out,
   output logic      [6:0]      clk_two_word_out
);
   logic [7:0][6:0] shift;
   logic [6:0]      sh_one;
   logic [6:0]      sh_two;
   logic [2:0]      bit_cnt = 3'h0;
   logic            locked = 1'b0;

   // framing follows the balance strap, as on the transmitter
   function automatic logic legal(input logic [6:0] w);
      return balance_select_in ? (w inside {7'h78, 7'h70, 7'h7c, 7'h60}) : (w == 7'h63);
   endfunction

   // sample mid-bit, on the falling link edge
   always @(negedge link_clk_in) begin
      for (int k = 0; k < 8; k++) begin
         shift[k] = {shift[k][5:0], data_lane_in[k]};
      end
      sh_one = {sh_one[5:0], clk_one_in};
      sh_two = {sh_two[5:0], clk_two_in};
      bit_cnt = (bit_cnt == 3'h6) ? 3'h0 : bit_cnt + 3'h1;
      if ((locked && bit_cnt == 3'h0) || (!locked && legal(sh_one))) begin
         locked = legal(sh_one);
         bit_cnt = 3'h0;
         data_word_out = shift;
         clk_one_word_out = sh_one;
         clk_two_word_out = sh_two;
      end
   end
endmodule

// ---- sim/test_dcbe_encoder.sv ----
// Purpose: self-checking bench of the balanced line encoder
// Assumes: all pixel lanes carry the same slice, so all disparities agree
// Notes:   words are checked in steady states since the link drops some
`timescale 1ns/10ps
module test_dcbe_encoder;
   import dcbe_pkg::*;
   localparam logic [5:0] WL [9] = '{6'h3f, 6'h3f, 6'h00, 6'h07, 6'h00, 6'h01,
                                     6'h3e, 6'h03, 6'h00};
   logic clock_in, link_clk_in, sys_rst_in, hsync_in, vsync_in, display_active_in;
   logic edge_sel, pol, balance_select, dual;
   logic [47:0] pixel_data_in;
   logic [7:0] oe, lanes;
   logic clk_one, clk_two, clk_two_oe;
   logic signed [4:0] rd;
   logic [7:0][6:0] rx_word;
   logic [6:0] clk_one_word, clk_two_word;
   int mismatches = 0;
   int n_compared = 0;

   dcbe_encoder i_dcbe_encoder (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
      .link_clk_in(link_clk_in), .pixel_data_in(pixel_data_in), .hsync_in(hsync_in),
      .vsync_in(vsync_in), .display_active_in(display_active_in),
      .primary_edge_select_in(edge_sel), .active_polarity_select_in(pol),
      .balance_select_in(balance_select), .pixel_width_select_in(dual), .data_lane_out(lanes),
      .data_lane_oe_out(oe), .serial_clock_lane_one_out(clk_one),
      .serial_clock_lane_two_out(clk_two), .serial_clock_lane_two_oe_out(clk_two_oe),
      .running_disparity_out(rd));
   dcbe_panel_rx i_dcbe_panel_rx (.link_clk_in(link_clk_in), .balance_select_in(balance_select),
      .data_lane_in(lanes), .clk_one_in(clk_one), .clk_two_in(clk_two),
      .data_word_out(rx_word), .clk_one_word_out(clk_one_word),
      .clk_two_word_out(clk_two_word));

   initial begin
      clock_in = 1'b0;
      forever #25 clock_in = ~clock_in;
   end
   initial begin
      link_clk_in = 1'b0;
      #3;
      forever #6 link_clk_in = ~link_clk_in;
   end

   task automatic compare(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic check_word(input logic [6:0] got, input logic [6:0] exp);
      compare({1'b0, got}, {1'b0, exp});
   endtask
   task automatic check_rd(input logic signed [4:0] got, input logic signed [4:0] exp);
      compare({3'h0, got}, {3'h0, exp});
   endtask
   task automatic check_bit(input logic got, input logic exp);
      compare({7'h00, got}, {7'h00, exp});
   endtask

   function automatic logic signed [4:0] rd_step(input logic signed [4:0] r,
                                                 input logic [5:0] d);
      int disp;
      int nr;
      logic inv;
      disp = 2 * $countones(d) - 6;
      inv = (r == 0) || (r > 0 && disp > 0) || (r < 0 && disp <= 0);
      nr = inv ? r + 1 - disp : r + disp - 1;
      nr = (nr > 7) ? 7 : (nr < -6) ? -6 : nr;
      return 5'(nr);
   endfunction
   function automatic logic [6:0] ctl_word(input logic v, input logic signed [4:0] r);
      if (v) return (r > 0) ? DCBE_CTL1_POS : DCBE_CTL1_NEG;
      return (r > 0) ? DCBE_CTL0_POS : DCBE_CTL0_NEG;
   endfunction

   task automatic do_reset(input logic e, input logic p, input logic b, input logic w);
      @(posedge clock_in);
      sys_rst_in <= 1'b1;
      {edge_sel, pol, balance_select, dual} <= {e, p, b, w};
      display_active_in <= !p;
      repeat (4) @(posedge clock_in);
      sys_rst_in <= 1'b0;
      repeat (4) @(posedge clock_in);
      #1 check_rd(rd, 5'sd0);
   endtask
   task automatic drive(input logic [5:0] d, input logic hs, input logic vs, input logic act);
      @(posedge clock_in);
      pixel_data_in <= {8{d}};
      hsync_in <= hs;
      vsync_in <= vs;
      display_active_in <= act ~^ pol;
   endtask
   task automatic settle();
      repeat (30) @(posedge clock_in);
      #1;
   endtask
   task automatic blank_check(input logic hs, input logic vs, input logic signed [4:0] r);
      check_word(rx_word[0], ctl_word(hs, r));
      check_word(rx_word[1], ctl_word(vs, r));
      for (int k = 2; k < (dual ? 8 : 4); k++) check_word(rx_word[k], ctl_word(1'b0, r));
      check_word(clk_one_word, ctl_word(1'b1, r));
      if (dual) check_word(clk_two_word, clk_one_word);
   endtask

   task automatic t_single();
      do_reset(1'b0, 1'b1, 1'b1, 1'b0);
      for (int k = 0; k < 8; k++) check_bit(oe[k], k < 4);
      check_bit(clk_two_oe, 1'b0);
      drive(6'h00, 1'b1, 1'b0, 1'b0);
      settle();
      blank_check(1'b1, 1'b0, 5'sd0);
      repeat (14) @(negedge link_clk_in) check_bit(clk_two, 1'b0);
      $display("test single done");
   endtask
   task automatic t_stream(input logic e);
      logic signed [4:0] got [14];
      logic signed [4:0] exp [9];
      logic signed [4:0] r;
      do_reset(e, 1'b1, 1'b1, 1'b1);
      check_bit(clk_two_oe, 1'b1);
      r = 5'sd0;
      for (int i = 0; i < 9; i++) begin
         r = rd_step(r, WL[i]);
         exp[i] = r;
      end
      for (int i = 0; i < 14; i++) begin
         drive((i < 9) ? WL[i] : 6'h00, 1'b0, 1'b1, i < 9);
         #1 got[i] = rd;
      end
      // capture edge, then lane register: two cycles on either primary edge
      for (int i = 0; i < 9; i++) check_rd(got[i + 2], exp[i]);
      settle();
      check_rd(rd, r);
      blank_check(1'b0, 1'b1, r);
      $display("test stream edge %0d done", e);
   endtask
   task automatic t_active();
      do_reset(1'b0, 1'b1, 1'b1, 1'b1);
      drive(6'h07, 1'b0, 1'b0, 1'b1);
      settle();
      repeat (8) begin
         repeat (5) @(posedge clock_in);
         #1;
         for (int k = 0; k < 8; k++) check_word(rx_word[k], rx_word[k][0] ? 7'h71 : 7'h0e);
         check_word(clk_one_word, rx_word[0][0] ? DCBE_CTL0_NEG : DCBE_CTL0_POS);
         check_word(clk_two_word, clk_one_word);
      end
      $display("test active done");
   endtask
   task automatic t_polarity();
      do_reset(1'b0, 1'b0, 1'b1, 1'b1);
      repeat (10) drive(6'h00, 1'b0, 1'b0, 1'b0);
      settle();
      check_rd(rd, 5'sd0);
      check_word(clk_one_word, ctl_word(1'b1, 5'sd0));
      drive(6'h00, 1'b0, 1'b0, 1'b1);
      drive(6'h00, 1'b0, 1'b0, 1'b0);
      settle();
      check_rd(rd, 5'sd7);
      check_word(clk_one_word, ctl_word(1'b1, 5'sd7));
      $display("test polarity done");
   endtask
   task automatic t_plain();
      do_reset(1'b0, 1'b1, 1'b0, 1'b1);
      drive(6'h2a, 1'b1, 1'b0, 1'b1);
      settle();
      check_rd(rd, 5'sd0);
      for (int k = 0; k < 8; k++) check_word(rx_word[k], {6'h2a, k == 0 || k == 2});
      check_word(clk_one_word, DCBE_CLK_PLAIN);
      $display("test plain done");
   endtask

   task automatic summarize();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   initial begin
      #100000;
      mismatches++;
      summarize();
   end
   initial begin
      sys_rst_in = 1'b1;
      {edge_sel, pol, balance_select, dual} = 4'h0;
      {hsync_in, vsync_in, display_active_in} = 3'h0;
      pixel_data_in = 48'h0;
      t_single();
      t_stream(1'b0);
      t_stream(1'b1);
      t_active();
      t_polarity();
      t_plain();
      summarize();
   end
endmodule
